// file: bench/sfsr_ctrl_model.sv
// bus controller model issuing queries and commands
`timescale 1ns/1ps
`default_nettype none
module sfsr_ctrl_model (
  input wire logic clk,
  input wire logic resp_valid,
  input wire logic [8:0] resp_value,
  output logic [10:0] pulses,
  output logic [8:0] mask_wr_value
);
  logic [8:0] last_answer_r;
  int answers_r;
  initial begin
    pulses = 11'h000;
    mask_wr_value = 9'h000;
    last_answer_r = 9'h000;
    answers_r = 0;
  end
  // ---------------------------------------------------------------
  // one bus cycle of pulses
  // ---------------------------------------------------------------
  // mask value driven on a write, complemented otherwise
  task automatic cycle(input logic [10:0] p, input logic [8:0] v);
    @(posedge clk);
    #2;
    pulses = p;
    mask_wr_value = p[5] ? v : ~mask_wr_value;
  endtask : cycle
  // ---------------------------------------------------------------
  // answer capture
  // ---------------------------------------------------------------
  // talker takes answer
  always @(posedge clk) begin
    if (resp_valid === 1'b1) begin
      last_answer_r <= resp_value;
      answers_r <= answers_r + 1;
    end
  end
endmodule : sfsr_ctrl_model
`default_nettype wire

// file: bench/tb.sv
// self-checking testbench of the status and fault core
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk;
  logic rst;
  logic [8:0] cond;
  wire logic [10:0] p;
  wire logic [8:0] mwv;
  logic [8:0] live_status, resp_value;
  logic [7:0] hun, ten, one, poll;
  logic [2:0] resp_kind;
  logic [1:0] nd;
  logic resp_valid, fsum, pon_bit, srq;
  logic [8:0] e_mask, e_fault, e_acc, p_live, p_mask, e_val, set, nf, na;
  logic [2:0] e_kind;
  logic e_en, e_srq, e_pon, p_sum, e_rv;
  logic [10:0] pr;
  int seed, num_errors, checks_done, cyc, e_ans;

  sfsr_ctrl_model ctrl (.clk(clk), .resp_valid(resp_valid),
    .resp_value(resp_value), .pulses(p), .mask_wr_value(mwv));

  sfsr_status_core dut (.clk(clk), .rst(rst),
    .remote_inhibit_flag(cond[8]), .prog_error_flag(cond[7]),
    .foldback_trip_flag(cond[6]), .line_dropout_flag(cond[5]),
    .overtemp_flag(cond[4]), .overvoltage_flag(cond[3]),
    .overrange_flag(cond[2]), .const_current_flag(cond[1]),
    .const_voltage_flag(cond[0]), .status_query(p[0]),
    .accum_status_query(p[1]), .mask_query(p[2]), .fault_query(p[3]),
    .srq_enable_query(p[4]), .mask_write_command(p[5]),
    .mask_wr_value(mwv), .srq_on_cmd(p[6]), .srq_off_cmd(p[7]),
    .clear_command(p[8]), .device_clear(p[9]), .serial_poll_read(p[10]),
    .live_status(live_status), .resp_valid(resp_valid),
    .resp_kind(resp_kind), .resp_value(resp_value), .resp_hundreds(hun),
    .resp_tens(ten), .resp_ones(one), .resp_ndigits(nd),
    .fault_summary_bit(fsum), .power_on_event_bit(pon_bit),
    .poll_byte(poll), .srq(srq));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic close_out();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  function automatic logic [25:0] dec(input logic [8:0] v);
    logic [1:0] n;
    n = (v > 9'h063) ? 2'h3 : (v > 9'h009) ? 2'h2 : 2'h1;
    return {sfsr_pkg::ASCII_ZERO + 8'(v / 9'h064),
      sfsr_pkg::ASCII_ZERO + 8'((v / 9'h00a) % 9'h00a),
      sfsr_pkg::ASCII_ZERO + 8'(v % 9'h00a), n};
  endfunction : dec

  task automatic step(input logic [10:0] pl, input logic [8:0] v,
    input logic [8:0] c);
    ctrl.cycle(pl, v);
    cond = c;
  endtask : step
  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      close_out();
    end
    if (rst) begin
      {e_mask, e_fault, p_mask} = 27'h0;
      e_acc = cond;
      p_live = cond;
      {e_en, e_srq, p_sum, e_rv} = 4'h0;
      e_pon = 1'b1;
    end else begin
      set = cond & e_mask & ~(p_live & p_mask);
      nf = e_fault | set;
      na = e_acc | cond;
      e_rv = |p[4:0];
      if (e_rv) e_ans++;
      if (e_en && |e_fault && !p_sum) e_srq = 1'b1;
      else if (p[10]) e_srq = 1'b0;
      p_sum = |e_fault;
      if (p[0]) {e_kind, e_val} = {sfsr_pkg::KIND_STATUS, cond};
      else if (p[1]) begin
        {e_kind, e_val} = {sfsr_pkg::KIND_ACCUM, na};
        na = cond;
      end else if (p[2]) {e_kind, e_val} = {sfsr_pkg::KIND_MASK, e_mask};
      else if (p[3]) begin
        {e_kind, e_val} = {sfsr_pkg::KIND_FAULT, e_fault};
        nf = set;
      end else if (p[4]) {e_kind, e_val} = {sfsr_pkg::KIND_SRQEN, 8'h00, e_en};
      p_live = cond;
      p_mask = e_mask;
      e_fault = nf;
      e_acc = na;
      if (p[5]) e_mask = mwv;
      if (p[6]) e_en = 1'b1;
      else if (p[7]) e_en = 1'b0;
      if (p[8] | p[9]) e_pon = 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // per-cycle comparison
  // ---------------------------------------------------------------
  always @(negedge clk) begin
    if (!rst) begin
      chk("live", live_status, cond); // live word
      chk("valid", resp_valid, e_rv); // answer pulse
      if (e_rv) begin
        chk("kind", resp_kind, e_kind); // answer kind
        chk("value", resp_value, e_val); // answer value
        chk("digits", {hun, ten, one, nd}, dec(e_val)); // text
      end
      chk("summary", fsum, |e_fault); // summary bit
      chk("srq", srq, e_srq); // service request
      chk("pon", pon_bit, e_pon); // power-on bit
      chk("poll", poll,
        {1'b0, e_srq, 2'h0, |e_fault, 1'b0, cond[7], e_pon});
    end
  end
  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial begin
    seed = 46241;
    num_errors = 0;
    checks_done = 0;
    cyc = 0;
    e_ans = 0;
    rst = 1'b1;
    cond = 9'h0a3;
    repeat (8) @(posedge clk);
    #2;
    rst = 1'b0;
    step(11'h002, 9'h000, 9'h0a3); // accum after reset
    step(11'h050, 9'h000, 9'h0a3); // enable on, query old
    step(11'h024, 9'h086, 9'h0a3); // mask write 134
    step(11'h004, 9'h000, 9'h0a3); // mask query
    step(11'h010, 9'h000, 9'h0a3); // masked true bits
    step(11'h002, 9'h000, 9'h0a3); // accum query
    step(11'h400, 9'h000, 9'h0a3); // poll read
    step(11'h008, 9'h000, 9'h0a7); // fault query with rise
    step(11'h008, 9'h000, 9'h0a7); // fault query again
    step(11'h000, 9'h000, 9'h0a3); // condition falls
    step(11'h000, 9'h000, 9'h0a7); // new rise
    step(11'h001, 9'h000, 9'h0a7); // status query
    step(11'h021, 9'h000, 9'h0a7); // mask zero
    step(11'h0c0, 9'h000, 9'h1ff); // on and off together
    step(11'h010, 9'h000, 9'h1ff); // enable query
    step(11'h100, 9'h000, 9'h1ff); // clear command
    step(11'h002, 9'h000, 9'h000); // accum holds past ones
    repeat (3000) begin
      pr = 11'($random(seed) & $random(seed) & $random(seed));
      step(pr, 9'($random(seed)),
        cond ^ 9'($random(seed) & $random(seed) & $random(seed)));
    end
    step(11'h000, 9'h000, cond);
    rst = 1'b1;
    repeat (2) step(11'h000, 9'h000, cond);
    rst = 1'b0;
    step(11'h002, 9'h000, cond); // accum equals live after reset
    step(11'h008, 9'h000, cond); // faults clear after reset
    step(11'h000, 9'h000, cond);
    step(11'h000, 9'h000, cond);
    chk("answers", ctrl.answers_r, e_ans); // talker took every answer
    chk("last answer", ctrl.last_answer_r, e_val); // last answer seen
    close_out();
  end
endmodule : tb
`default_nettype wire

// file: logic/sfsr_dec_text.sv
// nine-bit value to three ascii decimal digits
`timescale 1ns/1ps
`default_nettype none
module sfsr_dec_text (
  input wire logic [8:0] value,
  output logic [7:0] hundreds,
  output logic [7:0] tens,
  output logic [7:0] ones,
  output logic [1:0] ndigits
);
  // ---------------------------------------------------------------
  // digit extraction
  // ---------------------------------------------------------------
  function automatic logic [7:0] dec_digit(input logic [8:0] v,
                                           input logic [8:0] div);
    logic [8:0] q;
    q = (v / div) % sfsr_pkg::DEC_TEN;
    dec_digit = sfsr_pkg::ASCII_ZERO + {4'h0, q[3:0]};
  endfunction : dec_digit

  always_comb begin
    hundreds = dec_digit(value, sfsr_pkg::DEC_HUNDRED);
    tens = dec_digit(value, sfsr_pkg::DEC_TEN);
    ones = dec_digit(value, sfsr_pkg::DEC_ONE);
    if (value >= sfsr_pkg::DEC_HUNDRED) begin
      ndigits = sfsr_pkg::NDIG_THREE;
    end else if (value >= sfsr_pkg::DEC_TEN) begin
      ndigits = sfsr_pkg::NDIG_TWO;
    end else begin
      ndigits = sfsr_pkg::NDIG_ONE;
    end
  end
endmodule : sfsr_dec_text
`default_nettype wire

// file: logic/sfsr_status_core.sv
// status, accumulated status, mask, fault and service request logic
`timescale 1ns/1ps
`default_nettype none
module sfsr_status_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic remote_inhibit_flag,
  input wire logic prog_error_flag,
  input wire logic foldback_trip_flag,
  input wire logic line_dropout_flag,
  input wire logic overtemp_flag,
  input wire logic overvoltage_flag,
  input wire logic overrange_flag,
  input wire logic const_current_flag,
  input wire logic const_voltage_flag,
  input wire logic status_query,
  input wire logic accum_status_query,
  input wire logic mask_query,
  input wire logic fault_query,
  input wire logic srq_enable_query,
  input wire logic mask_write_command,
  input wire logic [8:0] mask_wr_value,
  input wire logic srq_on_cmd,
  input wire logic srq_off_cmd,
  input wire logic clear_command,
  input wire logic device_clear,
  input wire logic serial_poll_read,
  output logic [8:0] live_status,
  output logic resp_valid,
  output logic [2:0] resp_kind,
  output logic [8:0] resp_value,
  output logic [7:0] resp_hundreds,
  output logic [7:0] resp_tens,
  output logic [7:0] resp_ones,
  output logic [1:0] resp_ndigits,
  output logic fault_summary_bit,
  output logic power_on_event_bit,
  output logic [7:0] poll_byte,
  output logic srq
);
  // ---------------------------------------------------------------
  // live status word
  // ---------------------------------------------------------------
  logic [8:0] live_w;
  logic [8:0] live_prev_r;
  logic [8:0] accum_r;
  logic [8:0] accum_nxt;
  logic [8:0] mask_r;
  logic [8:0] mask_prev_r;
  logic [8:0] fault_r;
  logic [8:0] fault_nxt;
  logic [8:0] rise_set_w;
  logic [8:0] mask_set_w;
  logic [8:0] set_w;
  logic srq_en_r;
  logic fs_prev_r;
  logic srq_r;
  logic pon_r;
  logic ans_status;
  logic ans_accum;
  logic ans_mask;
  logic ans_fault;
  logic ans_srqen;
  logic [2:0] sel_kind;
  logic [8:0] sel_value;
  logic [7:0] dig_h;
  logic [7:0] dig_t;
  logic [7:0] dig_o;
  logic [1:0] dig_n;

  always_comb begin
    live_w = sfsr_pkg::COND_ZERO;
    live_w[sfsr_pkg::POS_RI] = remote_inhibit_flag;
    live_w[sfsr_pkg::POS_ERR] = prog_error_flag;
    live_w[sfsr_pkg::POS_FOLDBACK_TRIP_FLAG] = foldback_trip_flag;
    live_w[sfsr_pkg::POS_LINE] = line_dropout_flag;
    live_w[sfsr_pkg::POS_OT] = overtemp_flag;
    live_w[sfsr_pkg::POS_OV] = overvoltage_flag;
    live_w[sfsr_pkg::POS_ORNG] = overrange_flag;
    live_w[sfsr_pkg::POS_CC] = const_current_flag;
    live_w[sfsr_pkg::POS_CV] = const_voltage_flag;
  end

  assign live_status = live_w;

  // ---------------------------------------------------------------
  // query selection, one answer per cycle
  // ---------------------------------------------------------------
  always_comb begin
    ans_status = status_query;
    ans_accum = accum_status_query && !status_query;
    ans_mask = mask_query && !status_query && !accum_status_query;
    ans_fault = fault_query && !status_query && !accum_status_query
                && !mask_query;
    ans_srqen = srq_enable_query && !status_query && !accum_status_query
                && !mask_query && !fault_query;
  end

  always_comb begin
    sel_kind = sfsr_pkg::KIND_NONE;
    sel_value = sfsr_pkg::COND_ZERO;
    if (ans_status) begin
      sel_kind = sfsr_pkg::KIND_STATUS;
      sel_value = live_w;
    end else if (ans_accum) begin
      sel_kind = sfsr_pkg::KIND_ACCUM;
      sel_value = accum_r | live_w;
    end else if (ans_mask) begin
      sel_kind = sfsr_pkg::KIND_MASK;
      sel_value = mask_r;
    end else if (ans_fault) begin
      sel_kind = sfsr_pkg::KIND_FAULT;
      sel_value = fault_r;
    end else if (ans_srqen) begin
      sel_kind = sfsr_pkg::KIND_SRQEN;
      sel_value = {8'h00, srq_en_r};
    end
  end

  sfsr_dec_text u_dec (
    .value(sel_value),
    .hundreds(dig_h),
    .tens(dig_t),
    .ones(dig_o),
    .ndigits(dig_n)
  );

  // ---------------------------------------------------------------
  // answer registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_kind <= sfsr_pkg::KIND_NONE;
      resp_value <= sfsr_pkg::COND_ZERO;
      resp_hundreds <= sfsr_pkg::ASCII_ZERO;
      resp_tens <= sfsr_pkg::ASCII_ZERO;
      resp_ones <= sfsr_pkg::ASCII_ZERO;
      resp_ndigits <= sfsr_pkg::NDIG_ONE;
    end else begin
      resp_valid <= (sel_kind != sfsr_pkg::KIND_NONE);
      if (sel_kind != sfsr_pkg::KIND_NONE) begin
        resp_kind <= sel_kind;
        resp_value <= sel_value;
        resp_hundreds <= dig_h;
        resp_tens <= dig_t;
        resp_ones <= dig_o;
        resp_ndigits <= dig_n;
      end
    end
  end

  // ---------------------------------------------------------------
  // accumulated status
  // ---------------------------------------------------------------
  always_comb begin
    accum_nxt = accum_r | live_w;
    if (ans_accum) begin
      accum_nxt = live_w;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      accum_r <= live_w;
    end else begin
      accum_r <= accum_nxt;
    end
  end

  // ---------------------------------------------------------------
  // mask register and change history
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_r <= sfsr_pkg::COND_ZERO;
    end else if (mask_write_command) begin
      mask_r <= mask_wr_value;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      live_prev_r <= live_w;
      mask_prev_r <= sfsr_pkg::COND_ZERO;
    end else begin
      live_prev_r <= live_w;
      mask_prev_r <= mask_r;
    end
  end

  // ---------------------------------------------------------------
  // fault register
  // ---------------------------------------------------------------
  // same positions as status
  assign rise_set_w = live_w & ~live_prev_r & mask_r;
  // newly set mask on true condition
  assign mask_set_w = live_w & mask_r & ~mask_prev_r;
  assign set_w = rise_set_w | mask_set_w;

  always_comb begin
    fault_nxt = fault_r | set_w;
    // cleared after answer, new sets win
    if (ans_fault) begin
      fault_nxt = set_w;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fault_r <= sfsr_pkg::COND_ZERO;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  assign fault_summary_bit = |fault_r;

  // ---------------------------------------------------------------
  // service request
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      srq_en_r <= 1'b0;
    end else if (srq_on_cmd) begin
      srq_en_r <= 1'b1;
    end else if (srq_off_cmd) begin
      srq_en_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fs_prev_r <= 1'b0;
      srq_r <= 1'b0;
    end else begin
      fs_prev_r <= fault_summary_bit;
      if (srq_en_r && fault_summary_bit && !fs_prev_r) begin
        srq_r <= 1'b1;
      end else if (serial_poll_read) begin
        srq_r <= 1'b0;
      end
    end
  end

  assign srq = srq_r;

  // ---------------------------------------------------------------
  // power-on event and serial poll byte
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pon_r <= 1'b1;
    end else if (clear_command || device_clear) begin
      pon_r <= 1'b0;
    end
  end

  assign power_on_event_bit = pon_r;

  always_comb begin
    poll_byte = 8'h00;
    poll_byte[sfsr_pkg::POLL_PON] = pon_r;
    poll_byte[sfsr_pkg::POLL_ERR] = live_w[sfsr_pkg::POS_ERR];
    poll_byte[sfsr_pkg::POLL_FAU] = fault_summary_bit;
    poll_byte[sfsr_pkg::POLL_RQS] = srq_r;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  int txt_val;
  always_comb begin
    txt_val = 100 * (int'(resp_hundreds) - 48)
              + 10 * (int'(resp_tens) - 48) + (int'(resp_ones) - 48);
  end

  AST_TEXT_SUM: assert property (
    @(posedge clk) disable iff (rst)
    resp_valid |-> (txt_val == int'(resp_value)))
    else $error("answer text does not match value");

  AST_STATUS_ANS: assert property (
    @(posedge clk) disable iff (rst)
    status_query |=> (resp_valid && resp_kind == sfsr_pkg::KIND_STATUS
                      && resp_value == $past(live_w)))
    else $error("status answer wrong");

  AST_ACCUM_HOLD: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |=> ((accum_r & $past(live_w)) == $past(live_w)))
    else $error("accumulated lost a live bit");

  AST_ACCUM_RELOAD: assert property (
    @(posedge clk) disable iff (rst)
    ans_accum |=> (accum_r == $past(live_w)))
    else $error("accumulated not reloaded with live");

  AST_FAULT_RISE: assert property (
    @(posedge clk) disable iff (rst)
    (|rise_set_w) |=> ((fault_r & $past(rise_set_w)) == $past(rise_set_w)))
    else $error("rising status did not set fault");

  AST_FAULT_MASKSET: assert property (
    @(posedge clk) disable iff (rst)
    (|mask_write_command && |(mask_wr_value & ~mask_r & live_w))
    ##1 (live_w == $past(live_w))
    |=> ((fault_r & $past(live_w, 2) & $past(mask_wr_value, 2)
          & ~$past(mask_r, 2))
         == ($past(live_w, 2) & $past(mask_wr_value, 2)
             & ~$past(mask_r, 2))))
    else $error("new mask bit did not set fault");

  AST_FAULT_CLEAR: assert property (
    @(posedge clk) disable iff (rst)
    (ans_fault && set_w == sfsr_pkg::COND_ZERO) |=>
    (fault_r == sfsr_pkg::COND_ZERO && resp_kind == sfsr_pkg::KIND_FAULT))
    else $error("fault not cleared after query");

  AST_SUMMARY: assert property (
    @(posedge clk) disable iff (rst)
    (|set_w) |=> (fault_summary_bit && poll_byte[sfsr_pkg::POLL_FAU]))
    else $error("summary bit missing after fault set");

  AST_MASK_QUERY: assert property (
    @(posedge clk) disable iff (rst)
    (ans_mask && !mask_write_command) |=>
    (mask_r == $past(mask_r) && resp_value == $past(mask_r)))
    else $error("mask query wrong or mask changed");

  AST_SRQ_RISE: assert property (
    @(posedge clk) disable iff (rst)
    (srq_en_r && !srq_off_cmd && $rose(fault_summary_bit)) |=> srq ##1 1'b1)
    else $error("service request not raised");

  AST_SRQ_EN: assert property (
    @(posedge clk) disable iff (rst)
    (srq_off_cmd && !srq_on_cmd) |=> !srq_en_r)
    else $error("enable flag not cleared by off form");

  AST_PON_CLEAR: assert property (
    @(posedge clk) disable iff (rst)
    (clear_command || device_clear) |=>
    (!power_on_event_bit && !poll_byte[sfsr_pkg::POLL_PON]))
    else $error("power-on bit survived clear");
endmodule : sfsr_status_core
`default_nettype wire

// file: pkg/sfsr_pkg.sv
// constants shared by the status, fault and service request logic
`default_nettype none
package sfsr_pkg;
  // ---------------------------------------------------------------
  // condition bit positions (common to all four registers)
  // ---------------------------------------------------------------
  localparam int unsigned COND_W = 9;
  localparam int unsigned POS_RI = 8;
  localparam int unsigned POS_ERR = 7;
  localparam int unsigned POS_FOLDBACK_TRIP_FLAG = 6;
  localparam int unsigned POS_LINE = 5;
  localparam int unsigned POS_OT = 4;
  localparam int unsigned POS_OV = 3;
  localparam int unsigned POS_ORNG = 2;
  localparam int unsigned POS_CC = 1;
  localparam int unsigned POS_CV = 0;
  localparam logic [8:0] COND_ZERO = 9'h000;
  // ---------------------------------------------------------------
  // answer kinds
  // ---------------------------------------------------------------
  localparam logic [2:0] KIND_NONE = 3'h0;
  localparam logic [2:0] KIND_STATUS = 3'h1;
  localparam logic [2:0] KIND_ACCUM = 3'h2;
  localparam logic [2:0] KIND_MASK = 3'h3;
  localparam logic [2:0] KIND_FAULT = 3'h4;
  localparam logic [2:0] KIND_SRQEN = 3'h5;
  // ---------------------------------------------------------------
  // serial poll byte layout
  // ---------------------------------------------------------------
  localparam int unsigned POLL_PON = 0;
  localparam int unsigned POLL_ERR = 1;
  localparam int unsigned POLL_FAU = 3;
  localparam int unsigned POLL_RQS = 6;
  // ---------------------------------------------------------------
  // decimal text
  // ---------------------------------------------------------------
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [8:0] DEC_HUNDRED = 9'h064;
  localparam logic [8:0] DEC_TEN = 9'h00a;
  localparam logic [8:0] DEC_ONE = 9'h001;
  localparam logic [1:0] NDIG_ONE = 2'h1;
  localparam logic [1:0] NDIG_TWO = 2'h2;
  localparam logic [1:0] NDIG_THREE = 2'h3;
endpackage : sfsr_pkg
`default_nettype wire
